// File: core/updown_timer_pkg.sv
// constants and types for the up/down timer control block
package updown_timer_pkg;

  localparam logic [31:0] ADDR_CAPCOMP_MODE    = 32'hFFFFF5EA;
  localparam logic [31:0] ADDR_UNIT_MODE       = 32'hFFFFF5EB;
  localparam logic [31:0] ADDR_TIMER_CONTROL   = 32'hFFFFF5EC;
  localparam logic [31:0] ADDR_PIN_EDGE        = 32'hFFFFF5ED;
  localparam logic [31:0] ADDR_PRESCALER       = 32'hFFFFF5EE;
  localparam logic [31:0] ADDR_COUNTER_STATUS  = 32'hFFFFF5EF;
  localparam logic [31:0] ADDR_CAPTURE_SOURCE  = 32'hFFFFF5F6;

  localparam logic [7:0]  RST_CAPCOMP_MODE     = 8'h00;
  localparam logic [7:0]  RST_UNIT_MODE        = 8'h00;
  localparam logic [7:0]  RST_TIMER_CONTROL    = 8'h00;
  localparam logic [7:0]  RST_PIN_EDGE         = 8'h00;
  localparam logic [7:0]  RST_PRESCALER        = 8'h07;
  localparam logic [7:0]  RST_CAPTURE_SOURCE   = 8'h00;

  // writable bit masks; reserved bits read zero
  localparam logic [7:0]  MASK_CAPCOMP_MODE    = 8'h03;
  localparam logic [7:0]  MASK_UNIT_MODE       = 8'h81;
  localparam logic [7:0]  MASK_TIMER_CONTROL   = 8'h4F;
  localparam logic [7:0]  MASK_PRESCALER       = 8'h07;
  localparam logic [7:0]  MASK_CAPTURE_SOURCE  = 8'h01;

  localparam int BIT_COUNT_ENABLE      = 6;
  localparam int BIT_INTERVAL_CLEAR    = 2;
  localparam int BIT_UNIT_MODE_UDC     = 7;
  localparam int BIT_UPDOWN_SUBMODE    = 0;
  localparam int BIT_UNDERFLOW         = 2;
  localparam int BIT_OVERFLOW          = 1;
  localparam int BIT_DIRECTION         = 0;

  // pin index into the synchroniser bank
  localparam int PIN_COUNT   = 0;
  localparam int PIN_DIR     = 1;
  localparam int PIN_CLEAR   = 2;
  localparam int PIN_CAP_A   = 3;
  localparam int PIN_CAP_B   = 4;
  localparam int NUM_PINS    = 5;

  localparam logic [1:0] EDGE_FALLING = 2'h0;
  localparam logic [1:0] EDGE_RISING  = 2'h1;
  localparam logic [1:0] EDGE_BAD     = 2'h2;
  localparam logic [1:0] EDGE_BOTH    = 2'h3;
  localparam logic [1:0] CLR_LEVEL_LO = 2'h2;
  localparam logic [1:0] CLR_LEVEL_HI = 2'h3;

  localparam logic [1:0] CLRSEL_EXT   = 2'h0;
  localparam logic [1:0] CLRSEL_MATCH = 2'h1;
  localparam logic [1:0] CLRSEL_BOTH  = 2'h2;
  localparam logic [1:0] CLRSEL_NONE  = 2'h3;

  localparam logic [15:0] COUNT_MAX   = 16'hFFFF;
  localparam logic [15:0] COUNT_ZERO  = 16'h0000;
  localparam int          PRESCALE_W  = 7;
  localparam int          CLK_PERIOD_NS = 100;

  typedef enum logic [4:0] {
    MODE_GP    = 5'b00001,
    MODE_UDC_1 = 5'b00010,
    MODE_UDC_2 = 5'b00100,
    MODE_UDC_3 = 5'b01000,
    MODE_UDC_4 = 5'b10000
  } count_mode_t;

endpackage

// File: core/pin_sync_edge.sv
// two-flop synchroniser with edge detection for one external pin
`timescale 1ns/1ps
module pin_sync_edge (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  // first flop feeds only the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= pin;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign level = sync_reg;
  assign rise  = sync_reg & ~prev_reg;
  assign fall  = ~sync_reg & prev_reg;

endmodule

// File: core/updown_timer_control.sv
// control, count and status logic of the 16-bit up/down timer
`timescale 1ns/1ps
module updown_timer_control
  import updown_timer_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [31:0] cpu_addr,
  input  wire logic        cpu_wr,
  input  wire logic        cpu_rd,
  input  wire logic [7:0]  cpu_wdata,
  output logic      [7:0]  cpu_rdata,
  output logic             cpu_rd_valid,
  input  wire logic [15:0] compare_a,
  input  wire logic [15:0] compare_b,
  input  wire logic        count_pulse_input,
  input  wire logic        direction_input,
  input  wire logic        ext_clear_input,
  input  wire logic        capture_pin_a,
  input  wire logic        capture_pin_b,
  output logic      [15:0] main_counter,
  output logic             capture_a_evt,
  output logic             capture_b_evt,
  output logic             chan_a_compare,
  output logic             chan_b_compare
);

  logic [7:0]            capcomp_mode_select_reg;
  logic [7:0]            timer_unit_mode_reg;
  logic [7:0]            timer_control_reg;
  logic [7:0]            pin_edge_select_reg;
  logic [7:0]            prescaler_count_mode_reg;
  logic [7:0]            capture_source_select_reg;
  logic                  overflow_flag_reg;
  logic                  underflow_flag_reg;
  logic                  direction_reg;
  logic [15:0]           counter_reg;
  logic [15:0]           counter_next;
  logic [PRESCALE_W-1:0] divider_reg;
  logic [7:0]            rdata_reg;
  logic                  rd_valid_reg;
  logic                  cap_a_reg;
  logic                  cap_b_reg;

  logic [NUM_PINS-1:0]   pin_bus;
  logic [NUM_PINS-1:0]   pin_level;
  logic [NUM_PINS-1:0]   pin_rise;
  logic [NUM_PINS-1:0]   pin_fall;

  assign pin_bus = {capture_pin_b, capture_pin_a, ext_clear_input,
                    direction_input, count_pulse_input};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
      pin_sync_edge u_sync (
        .clk   (clk),
        .rst   (rst),
        .pin   (pin_bus[gi]),
        .level (pin_level[gi]),
        .rise  (pin_rise[gi]),
        .fall  (pin_fall[gi])
      );
    end
  endgenerate

  // valid-edge decode; the prohibited code detects nothing
  function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
    logic hit;
    hit = 1'b0;
    unique case (sel)
      EDGE_FALLING: hit = f;
      EDGE_RISING:  hit = r;
      EDGE_BOTH:    hit = r | f;
      default:      hit = 1'b0;
    endcase
    return hit;
  endfunction

  // register decode
  wire sel_capcomp = cpu_addr == ADDR_CAPCOMP_MODE;
  wire sel_unit    = cpu_addr == ADDR_UNIT_MODE;
  wire sel_control = cpu_addr == ADDR_TIMER_CONTROL;
  wire sel_edge    = cpu_addr == ADDR_PIN_EDGE;
  wire sel_presc   = cpu_addr == ADDR_PRESCALER;
  wire sel_status  = cpu_addr == ADDR_COUNTER_STATUS;
  wire sel_source  = cpu_addr == ADDR_CAPTURE_SOURCE;
  wire status_read = cpu_rd & sel_status;

  // mode fields
  wire       count_enable_bit      = timer_control_reg[BIT_COUNT_ENABLE];
  wire       interval_clear_enable = timer_control_reg[BIT_INTERVAL_CLEAR];
  wire [1:0] clear_select          = timer_control_reg[1:0];
  wire       updown_count_mode     = timer_unit_mode_reg[BIT_UNIT_MODE_UDC];
  wire       updown_submode_select = timer_unit_mode_reg[BIT_UPDOWN_SUBMODE];
  wire [1:0] encoder_edge_sel      = pin_edge_select_reg[7:6];
  wire [1:0] clear_edge_sel        = pin_edge_select_reg[5:4];
  wire [1:0] capb_edge_sel         = pin_edge_select_reg[3:2];
  wire [1:0] capa_edge_sel         = pin_edge_select_reg[1:0];
  wire [2:0] prescale_sel          = prescaler_count_mode_reg[2:0];
  wire       chan_a_mode_bit       = capcomp_mode_select_reg[0];
  wire       chan_b_mode_bit       = capcomp_mode_select_reg[1];
  wire       chan_b_source_bit     = capture_source_select_reg[0];

  wire udc_mode_a = updown_count_mode & ~updown_submode_select;
  wire udc_mode_b = updown_count_mode & updown_submode_select;

  count_mode_t count_mode;
  assign count_mode = !updown_count_mode     ? MODE_GP    :
                      prescale_sel == 3'h4   ? MODE_UDC_1 :
                      prescale_sel == 3'h5   ? MODE_UDC_2 :
                      prescale_sel == 3'h6   ? MODE_UDC_3 :
                      prescale_sel == 3'h7   ? MODE_UDC_4 : MODE_GP;

  // prescaler tick; code 000 gives no tick at all
  wire [7:0] div_mask8 = (8'h01 << prescale_sel) - 8'h01;
  wire [PRESCALE_W-1:0] div_mask = div_mask8[PRESCALE_W-1:0];
  wire gp_tick = count_enable_bit & (count_mode == MODE_GP) & (prescale_sel != 3'h0) &
                 ((divider_reg & div_mask) == div_mask);

  // encoder edges, qualified by the shared edge select
  wire cnt_ev  = edge_hit(encoder_edge_sel, pin_rise[PIN_COUNT], pin_fall[PIN_COUNT]);
  wire dir_ev  = edge_hit(encoder_edge_sel, pin_rise[PIN_DIR], pin_fall[PIN_DIR]);
  wire dir_lvl = pin_level[PIN_DIR];
  wire phase_a = pin_level[PIN_COUNT];
  wire phase_b = pin_level[PIN_DIR];
  wire quad_up = (cnt_ev & (phase_a ^ phase_b)) | (dir_ev & ~(phase_a ^ phase_b));

  logic udc_up;
  logic udc_dn;
  always_comb begin
    udc_up = 1'b0;
    udc_dn = 1'b0;
    unique case (count_mode)
      MODE_UDC_1: begin
        udc_up = cnt_ev & ~dir_lvl;
        udc_dn = cnt_ev & dir_lvl;
      end
      MODE_UDC_2: begin
        udc_up = cnt_ev & ~dir_ev;
        udc_dn = dir_ev & ~cnt_ev;
      end
      MODE_UDC_3: begin
        udc_up = cnt_ev & dir_lvl;
        udc_dn = cnt_ev & ~dir_lvl;
      end
      MODE_UDC_4: begin
        // both phases changing at once is a lost step, not a count
        udc_up = (cnt_ev ^ dir_ev) & quad_up;
        udc_dn = (cnt_ev ^ dir_ev) & ~quad_up;
      end
      MODE_GP: begin
        udc_up = 1'b0;
        udc_dn = 1'b0;
      end
    endcase
  end

  wire step_up = (count_enable_bit & udc_up) | gp_tick;
  wire step_dn = count_enable_bit & udc_dn;

  // external clear, decoded only in mode A
  wire ext_src_on = udc_mode_a & ((clear_select == CLRSEL_EXT) |
                                  (clear_select == CLRSEL_BOTH));
  wire ext_hit    = (clear_edge_sel == EDGE_FALLING) ? pin_fall[PIN_CLEAR] :
                    (clear_edge_sel == EDGE_RISING)  ? pin_rise[PIN_CLEAR] :
                    (clear_edge_sel == CLR_LEVEL_LO) ? ~pin_level[PIN_CLEAR] :
                                                        pin_level[PIN_CLEAR];
  wire ext_clear  = ext_src_on & ext_hit;

  wire match_src_a = udc_mode_a & ((clear_select == CLRSEL_MATCH) |
                                   (clear_select == CLRSEL_BOTH));
  wire match_a     = counter_reg == compare_a;
  wire match_b     = counter_reg == compare_b;
  wire up_clear    = step_up & match_a &
                     ((~updown_count_mode & interval_clear_enable) | match_src_a |
                      udc_mode_b);
  wire dn_clear    = step_dn & match_b & udc_mode_b;
  wire any_clear   = ext_clear | up_clear | dn_clear;

  wire ovf_set = step_up & ~any_clear & (counter_reg == COUNT_MAX);
  wire udf_set = step_dn & ~any_clear & (counter_reg == COUNT_ZERO);

  always_comb begin
    if (any_clear) begin
      counter_next = COUNT_ZERO;
    end else if (step_up) begin
      counter_next = counter_reg + 16'h0001;
    end else if (step_dn) begin
      counter_next = counter_reg - 16'h0001;
    end else begin
      counter_next = counter_reg;
    end
  end

  // capture triggers; dead while counting is disabled
  wire cap_a_edge = edge_hit(capa_edge_sel, pin_rise[PIN_CAP_A], pin_fall[PIN_CAP_A]);
  wire cap_b_edge = edge_hit(capb_edge_sel, pin_rise[PIN_CAP_B], pin_fall[PIN_CAP_B]);
  wire cap_b_trig = chan_b_source_bit ? cap_a_edge : cap_b_edge;
  wire cap_a_next = count_enable_bit & ~chan_a_mode_bit & cap_a_edge;
  wire cap_b_next = count_enable_bit & ~chan_b_mode_bit & cap_b_trig;

  wire [7:0] status_view = {5'h00, underflow_flag_reg, overflow_flag_reg,
                            direction_reg & updown_count_mode};

  wire [7:0] read_mux = sel_capcomp ? capcomp_mode_select_reg   :
                        sel_unit    ? timer_unit_mode_reg       :
                        sel_control ? timer_control_reg         :
                        sel_edge    ? pin_edge_select_reg       :
                        sel_presc   ? prescaler_count_mode_reg  :
                        sel_status  ? status_view               :
                        sel_source  ? capture_source_select_reg : 8'h00;

  // software keeps these stable while enabled; hardware does not lock them
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      capcomp_mode_select_reg   <= RST_CAPCOMP_MODE;
      timer_unit_mode_reg       <= RST_UNIT_MODE;
      timer_control_reg         <= RST_TIMER_CONTROL;
      pin_edge_select_reg       <= RST_PIN_EDGE;
      prescaler_count_mode_reg  <= RST_PRESCALER;
      capture_source_select_reg <= RST_CAPTURE_SOURCE;
    end else if (cpu_wr) begin
      if (sel_capcomp) capcomp_mode_select_reg   <= cpu_wdata & MASK_CAPCOMP_MODE;
      if (sel_unit)    timer_unit_mode_reg       <= cpu_wdata & MASK_UNIT_MODE;
      if (sel_control) timer_control_reg         <= cpu_wdata & MASK_TIMER_CONTROL;
      if (sel_edge)    pin_edge_select_reg       <= cpu_wdata;
      if (sel_presc)   prescaler_count_mode_reg  <= cpu_wdata & MASK_PRESCALER;
      if (sel_source)  capture_source_select_reg <= cpu_wdata & MASK_CAPTURE_SOURCE;
    end
  end

  // status writes are dropped: the register is read-only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      overflow_flag_reg  <= 1'b0;
      underflow_flag_reg <= 1'b0;
      direction_reg      <= 1'b0;
    end else begin
      // a set in the clearing read's cycle survives
      overflow_flag_reg  <= ovf_set | (overflow_flag_reg & ~status_read);
      underflow_flag_reg <= udf_set | (underflow_flag_reg & ~status_read);
      if (!updown_count_mode) begin
        direction_reg <= 1'b0;
      end else if (step_up) begin
        direction_reg <= 1'b0;
      end else if (step_dn) begin
        direction_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      counter_reg  <= COUNT_ZERO;
      divider_reg  <= '0;
      rdata_reg    <= 8'h00;
      rd_valid_reg <= 1'b0;
      cap_a_reg    <= 1'b0;
      cap_b_reg    <= 1'b0;
    end else begin
      counter_reg  <= counter_next;
      divider_reg  <= count_enable_bit ? divider_reg + 7'h01 : 7'h00;
      rdata_reg    <= cpu_rd ? read_mux : 8'h00;
      rd_valid_reg <= cpu_rd;
      cap_a_reg    <= cap_a_next;
      cap_b_reg    <= cap_b_next;
    end
  end

  assign cpu_rdata      = rdata_reg;
  assign cpu_rd_valid   = rd_valid_reg;
  assign main_counter   = counter_reg;
  assign capture_a_evt  = cap_a_reg;
  assign capture_b_evt  = cap_b_reg;
  assign chan_a_compare = capcomp_mode_select_reg[0];
  assign chan_b_compare = capcomp_mode_select_reg[1];

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  ext_clear_zero_a: assert property (
    ext_clear |=> counter_reg == COUNT_ZERO)
    else $error("external clear did not zero the counter");

  down_match_keep_a: assert property (
    udc_mode_a & step_dn & ~ext_clear & (counter_reg != COUNT_ZERO)
    |=> counter_reg == $past(counter_reg) - 16'h0001)
    else $error("mode A down count did not decrement");

  gp_dir_zero_a: assert property (
    !updown_count_mode |=> !direction_reg)
    else $error("direction flag set in general-purpose mode");

  ovf_wrap_a: assert property (
    ovf_set |=> overflow_flag_reg && counter_reg == COUNT_ZERO)
    else $error("overflow wrap not flagged");

  udf_wrap_a: assert property (
    udf_set |=> underflow_flag_reg && counter_reg == COUNT_MAX)
    else $error("underflow wrap not flagged");

  flag_read_clear_a: assert property (
    status_read & ~ovf_set & ~udf_set |=> !overflow_flag_reg && !underflow_flag_reg)
    else $error("status read did not clear flags");

  // judged only while enable stays up; a disable resets the divider
  prescale_div2_a: assert property (
    count_enable_bit & (count_mode == MODE_GP) & (prescale_sel == 3'h1) & gp_tick
    ##1 count_enable_bit & (prescale_sel == 3'h1)
    ##1 count_enable_bit & (count_mode == MODE_GP) & (prescale_sel == 3'h1)
    |-> gp_tick && !$past(gp_tick))
    else $error("divide-by-2 tick spacing wrong");

  mode3_dir_a: assert property (
    (count_mode == MODE_UDC_3) & count_enable_bit & cnt_ev & ~any_clear
    |=> direction_reg == !$past(dir_lvl))
    else $error("mode 3 direction wrong");

  cap_disabled_a: assert property (
    !count_enable_bit |=> !capture_a_evt && !capture_b_evt)
    else $error("capture fired while disabled");

  cover_overflow_c: cover property (ovf_set);
  cover_quad_down_c: cover property ((count_mode == MODE_UDC_4) & step_dn);
  cover_mode_b_clear_c: cover property (dn_clear);

endmodule

// File: tb/quad_encoder_model.sv
// two-phase encoder model driving the count and direction pins
`timescale 1ns/1ps
module quad_encoder_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic step_up,
  input  wire logic step_down,
  input  wire logic slow,
  output logic      phase_a,
  output logic      phase_b,
  output logic      busy
);
  logic [1:0] pos_reg;
  logic [3:0] hold_reg;
  // gray order 00,10,11,01: phase a leads when stepping up
  assign phase_a = pos_reg[1] ^ pos_reg[0];
  assign phase_b = pos_reg[1];
  assign busy    = hold_reg != 4'h0;
  // one phase moves per step and holds 3 cycles at least, never both at once
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pos_reg  <= 2'h0;
      hold_reg <= 4'h0;
    end else if (!busy && (step_up || step_down)) begin
      pos_reg  <= step_up ? pos_reg + 2'h1 : pos_reg - 2'h1;
      hold_reg <= slow ? 4'h9 : 4'h3;
    end else if (busy) begin
      hold_reg <= hold_reg - 4'h1;
    end
  end
endmodule

// File: tb/test_updown_timer_control.sv
// self-checking bench of the up/down timer control block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected %s: expected %h, seen %h", nm, e, g); end end
module test_updown_timer_control
  import updown_timer_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [31:0] cpu_addr = 32'h0;
  logic        cpu_wr = 1'b0;
  logic        cpu_rd = 1'b0;
  logic [7:0]  cpu_wdata = 8'h00;
  logic [7:0]  cpu_rdata;
  logic        cpu_rd_valid;
  logic [15:0] compare_a = 16'h0003;
  logic [15:0] compare_b = 16'hFFF0;
  logic [4:0]  pins = 5'h00;
  logic        use_enc = 1'b0;
  logic        enc_up = 1'b0;
  logic        enc_dn = 1'b0;
  logic        enc_slow = 1'b0;
  logic        enc_a;
  logic        enc_b;
  logic        enc_busy;
  logic [15:0] main_counter;
  logic        cap_a;
  logic        cap_b;
  logic        cmp_a;
  logic        cmp_b;
  int          n_mismatch = 0;
  int          check_count = 0;
  int          ev_a = 0;
  int          ev_b = 0;
  int          k;
  logic [31:0] seed = 32'h00000051; // start value 81
  logic [31:0] r;
  logic [15:0] exp_cnt;
  logic [15:0] mx;
  logic [15:0] v0;
  logic        uf;
  logic        of;
  logic        dn;
  logic        up;
  logic [7:0]  d;
  // timer control last so nothing is written while enabled
  logic [31:0] adr [6] = '{ADDR_CAPCOMP_MODE, ADDR_UNIT_MODE, ADDR_PIN_EDGE,
                           ADDR_PRESCALER, ADDR_CAPTURE_SOURCE, ADDR_TIMER_CONTROL};
  logic [7:0]  rstv [6] = '{RST_CAPCOMP_MODE, RST_UNIT_MODE, RST_PIN_EDGE,
                            RST_PRESCALER, RST_CAPTURE_SOURCE, RST_TIMER_CONTROL};
  logic [7:0]  msk [6] = '{MASK_CAPCOMP_MODE, MASK_UNIT_MODE, 8'hFF,
                           MASK_PRESCALER, MASK_CAPTURE_SOURCE, MASK_TIMER_CONTROL};

  always #50 clk = ~clk;

  updown_timer_control DUT (
    .clk               (clk),
    .rst               (rst),
    .cpu_addr          (cpu_addr),
    .cpu_wr            (cpu_wr),
    .cpu_rd            (cpu_rd),
    .cpu_wdata         (cpu_wdata),
    .cpu_rdata         (cpu_rdata),
    .cpu_rd_valid      (cpu_rd_valid),
    .compare_a         (compare_a),
    .compare_b         (compare_b),
    .count_pulse_input (use_enc ? enc_a : pins[PIN_COUNT]),
    .direction_input   (use_enc ? enc_b : pins[PIN_DIR]),
    .ext_clear_input   (pins[PIN_CLEAR]),
    .capture_pin_a     (pins[PIN_CAP_A]),
    .capture_pin_b     (pins[PIN_CAP_B]),
    .main_counter      (main_counter),
    .capture_a_evt     (cap_a),
    .capture_b_evt     (cap_b),
    .chan_a_compare    (cmp_a),
    .chan_b_compare    (cmp_b)
  );

  quad_encoder_model enc (
    .clk       (clk),
    .rst       (rst),
    .step_up   (enc_up),
    .step_down (enc_dn),
    .slow      (enc_slow),
    .phase_a   (enc_a),
    .phase_b   (enc_b),
    .busy      (enc_busy)
  );

  always @(posedge clk) begin
    if (cap_a === 1'b1) ev_a++;
    if (cap_b === 1'b1) ev_b++;
  end

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function void step(input logic u);
    if (u && exp_cnt == COUNT_MAX) of = 1'b1;
    if (!u && exp_cnt == COUNT_ZERO) uf = 1'b1;
    exp_cnt = u ? exp_cnt + 16'h0001 : exp_cnt - 16'h0001;
    dn = !u;
  endfunction

  task cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task wr(input logic [31:0] a, input logic [7:0] v);
    cpu_addr = a;
    cpu_wdata = v;
    cpu_wr = 1'b1;
    cyc(1);
    cpu_wr = 1'b0;
    cyc(1);
  endtask

  task rd(input logic [31:0] a, output logic [7:0] v);
    cpu_addr = a;
    cpu_rd = 1'b1;
    cyc(1);
    cpu_rd = 1'b0;
    `CHK("read valid", 1'b1, cpu_rd_valid)
    v = cpu_rdata;
    cyc(1);
  endtask

  // pins pass sync and edge flops, so allow four cycles after the first change and six after the second
  task pulse(input int i);
    pins[i] = ~pins[i];
    cyc(4);
    pins[i] = ~pins[i];
    cyc(6);
  endtask

  task cfg(input logic [7:0] unit, input logic [7:0] pre, input logic [7:0] edg,
           input logic [7:0] ctl);
    wr(ADDR_TIMER_CONTROL, 8'h00);
    wr(ADDR_UNIT_MODE, unit);
    wr(ADDR_PRESCALER, pre);
    wr(ADDR_PIN_EDGE, edg);
    wr(ADDR_TIMER_CONTROL, ctl | 8'h40);
  endtask

  task zero();
    wr(ADDR_TIMER_CONTROL, 8'h00);
    wr(ADDR_UNIT_MODE, 8'h80);
    wr(ADDR_PIN_EDGE, 8'h10);
    use_enc = 1'b0;
    pins = 5'h00;
    cyc(4);
    pulse(PIN_CLEAR);
    `CHK("counter cleared while disabled", 16'h0000, main_counter)
    rd(ADDR_COUNTER_STATUS, d);
    exp_cnt = 16'h0000;
    uf = 1'b0;
    of = 1'b0;
  endtask

  task run_case(input logic [7:0] unit, input logic [7:0] edg, input logic [1:0] sel,
                input logic u, input int n, input int clr, input logic [15:0] cmp,
                input logic [15:0] ex);
    zero();
    compare_a = cmp;
    pins[PIN_DIR] = u;
    if (clr == 2) pins[PIN_CLEAR] = 1'b1;
    cfg(unit, 8'h06, 8'h40 | edg, {6'h00, sel});
    repeat (n) pulse(PIN_COUNT);
    if (clr == 1) pulse(PIN_CLEAR);
    `CHK("counter after clear case", ex, main_counter)
    pins[PIN_CLEAR] = 1'b0;
  endtask

  task stop_test();
    $display("comparisons %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #2000000;
    n_mismatch++;
    stop_test();
  end

  initial begin
    repeat (5) @(posedge clk);
    #2;
    rst = 1'b0;
    cyc(1);
    for (int i = 0; i < 6; i++) begin
      rd(adr[i], d);
      `CHK("reset value", rstv[i], d)
    end
    for (int i = 0; i < 6; i++) wr(adr[i], 8'hFF);
    for (int i = 0; i < 6; i++) begin
      rd(adr[i], d);
      `CHK("written value", 8'hFF & msk[i], d)
    end
    `CHK("channel modes", 2'h3, {cmp_b, cmp_a})
    wr(ADDR_TIMER_CONTROL, 8'h00);
    wr(ADDR_CAPCOMP_MODE, 8'h01);
    `CHK("channel modes", 2'h1, {cmp_b, cmp_a})
    wr(ADDR_COUNTER_STATUS, 8'hFF);
    rd(ADDR_COUNTER_STATUS, d);
    `CHK("status after write", 8'h00, d)
    rd(32'hFFFFF5F0, d);
    `CHK("unmapped read", 8'h00, d)
    $display("test registers done");
    for (int c = 1; c <= 3; c++) begin
      zero();
      compare_a = 16'h0002;
      cfg(8'h00, 8'(c), 8'h00, 8'h00);
      cyc(3);
      v0 = main_counter;
      cyc(4 << c);
      `CHK("ticks per window", 16'h0004, main_counter - v0)
    end
    zero();
    r = rnd();
    compare_a = 16'(r[2:0]) + 16'h0002;
    cfg(8'h00, 8'h01, 8'h00, 8'h04);
    mx = 16'h0000;
    repeat (60) begin
      cyc(1);
      if (main_counter > mx) mx = main_counter;
    end
    `CHK("interval peak", compare_a, mx)
    rd(ADDR_COUNTER_STATUS, d);
    `CHK("general mode status", 8'h00, d)
    $display("test general mode done");
    for (int m = 1; m <= 3; m++) begin
      zero();
      cfg(8'h80, 8'h03 + 8'(m), 8'h40, 8'h03);
      for (int i = 0; i < 8; i++) begin
        r = rnd();
        up = (i < 2) ? i[0] : r[0];
        if (m == 2) begin
          pulse(up ? PIN_COUNT : PIN_DIR);
        end else begin
          pins[PIN_DIR] = (m == 1) ? !up : up;
          cyc(4);
          pulse(PIN_COUNT);
        end
        step(up);
      end
      `CHK("counter in count mode", exp_cnt, main_counter)
      rd(ADDR_COUNTER_STATUS, d);
      `CHK("status flags", {5'h00, uf, of, dn}, d)
      rd(ADDR_COUNTER_STATUS, d);
      `CHK("status after read", {7'h00, dn}, d)
      $display("test count mode %0d done", m);
    end
    for (int e = 0; e < 4; e++) begin
      zero();
      pins[PIN_DIR] = 1'b1;
      cfg(8'h80, 8'h06, 8'(e) << 6, 8'h03);
      pulse(PIN_COUNT);
      `CHK("edge code count", (e == 3) ? 16'h2 : (e == 2) ? 16'h0 : 16'h1, main_counter)
    end
    zero();
    cfg(8'h80, 8'h07, 8'hC0, 8'h03);
    use_enc = 1'b1;
    for (int i = 0; i < 12; i++) begin
      r = rnd();
      up = r[0];
      enc_slow = r[1];
      enc_up = up;
      enc_dn = !up;
      cyc(1);
      enc_up = 1'b0;
      enc_dn = 1'b0;
      for (k = 0; k < 12 && enc_busy; k++) cyc(1);
      if (enc_busy) begin
        n_mismatch++;
        stop_test();
      end
      step(up);
    end
    cyc(6);
    `CHK("counter in quadrature mode", exp_cnt, main_counter)
    $display("test quadrature done");
    run_case(8'h80, 8'h10, 2'h1, 1, 5, 0, 16'h0003, 16'h0001);
    run_case(8'h80, 8'h10, 2'h0, 1, 5, 0, 16'h0003, 16'h0005);
    run_case(8'h80, 8'h10, 2'h3, 1, 2, 1, 16'h0003, 16'h0002);
    run_case(8'h80, 8'h10, 2'h2, 1, 2, 1, 16'h0003, 16'h0000);
    run_case(8'h80, 8'h10, 2'h1, 0, 4, 0, 16'hFFFD, 16'hFFFC);
    run_case(8'h80, 8'h00, 2'h0, 1, 2, 1, 16'h0003, 16'h0000);
    run_case(8'h80, 8'h30, 2'h0, 1, 2, 2, 16'h0003, 16'h0000);
    run_case(8'h81, 8'h10, 2'h0, 1, 2, 1, 16'h0003, 16'h0002);
    run_case(8'h81, 8'h10, 2'h3, 1, 5, 0, 16'h0003, 16'h0001);
    run_case(8'h81, 8'h10, 2'h0, 0, 17, 0, 16'h0003, 16'h0000);
    $display("test clear sources done");
    zero();
    wr(ADDR_CAPCOMP_MODE, 8'h00);
    for (int s = 0; s < 2; s++) begin
      wr(ADDR_TIMER_CONTROL, 8'h00);
      wr(ADDR_CAPTURE_SOURCE, 8'(s));
      cfg(8'h00, 8'h07, s ? 8'h0F : 8'h05, 8'h00);
      ev_a = 0;
      ev_b = 0;
      pulse(PIN_CAP_A);
      `CHK("channel a captures", s ? 2 : 1, ev_a)
      `CHK("channel b captures from pin a", s ? 2 : 0, ev_b)
      pulse(PIN_CAP_B);
      `CHK("channel b captures", s ? 2 : 1, ev_b)
    end
    wr(ADDR_TIMER_CONTROL, 8'h00);
    wr(ADDR_CAPCOMP_MODE, 8'h03);
    wr(ADDR_TIMER_CONTROL, 8'h40);
    ev_a = 0;
    ev_b = 0;
    pulse(PIN_CAP_A);
    `CHK("captures in compare mode", 0, ev_a + ev_b)
    $display("test captures done");
    stop_test();
  end
endmodule
